// >>> rtl/eag_defs.svh
// Purpose: Offsets, field positions, reset values and encodings of the
//          effective address generator.
// Assumes: 32-bit Avalon-MM data, byte offsets, word-aligned registers.
// Notes:   Included by the offset adder and the generator design modules.
`ifndef EAG_DEFS_SVH
`define EAG_DEFS_SVH

`define EAG_OFF_CTRL        5'h00
`define EAG_OFF_STATUS      5'h04
`define EAG_OFF_MASK        5'h08
`define EAG_OFF_LAST_OFFSET 5'h0c
`define EAG_OFF_LAST_LINEAR 5'h10

`define EAG_CTRL_ENABLE_BIT 0
`define EAG_ST_DONE_BIT     0
`define EAG_ST_FAULT_BIT    1
`define EAG_ST_ILLEGAL_BIT  2
`define EAG_ST_W            3

`define EAG_CTRL_RESET      1'h1
`define EAG_MASK_RESET      3'h0

`define EAG_REG_BASE_B      3'h3
`define EAG_REG_STACK_PTR   3'h4
`define EAG_REG_FRAME_PTR   3'h5
`define EAG_REG_SRC_INDEX   3'h6
`define EAG_REG_DEST_INDEX  3'h7

`define EAG_LIMIT_16        32'h0000ffff
`define EAG_EXTRA_CYCLES    1

`endif

// >>> rtl/eag_pkg.sv
// Purpose: Types shared by the effective address generator files.
// Assumes: Constants come from eag_defs.svh.
// Notes:   Mode codes are the decoder's encoding of the addressing mode.
package eag_pkg;

    typedef enum logic [3:0] {
        MODE_REGISTER       = 4'h0,
        MODE_IMMEDIATE      = 4'h1,
        MODE_DIRECT         = 4'h2,
        MODE_REG_INDIRECT   = 4'h3,
        MODE_BASED          = 4'h4,
        MODE_INDEX          = 4'h5,
        MODE_SCALED_INDEX   = 4'h6,
        MODE_BASED_INDEX    = 4'h7,
        MODE_BASED_SCALED   = 4'h8,
        MODE_BASED_INDEX_D  = 4'h9,
        MODE_BASED_SCALED_D = 4'ha
    } addr_mode_t;

    typedef enum logic [1:0] {
        DISP_NONE = 2'h0,
        DISP_8    = 2'h1,
        DISP_16   = 2'h2,
        DISP_32   = 2'h3
    } disp_size_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b01,
        ST_EXTRA = 2'b10
    } eag_state_t;

endpackage : eag_pkg

// >>> rtl/eag_sum_if.sv
// Purpose: Carries the three offset terms to the adder and the sum back.
// Assumes: Purely combinational path inside one clock domain.
// Notes:   Width selects truncation to 16 or 32 bits.
`timescale 1ns/1ps
interface eag_sum_if;
    logic [31:0] term_a;
    logic [31:0] term_b;
    logic [31:0] term_c;
    logic addr32;
    logic [31:0] sum;
    logic above_16;

    modport user (output term_a, output term_b, output term_c, output addr32,
                  input sum, input above_16);
    modport adder (input term_a, input term_b, input term_c, input addr32,
                   output sum, output above_16);
endinterface : eag_sum_if

// >>> rtl/offset_adder.sv
// Purpose: Three-term offset adder with address-width truncation.
// Assumes: Terms already zero or sign extended to 32 bits.
// Notes:   Combinational; the caller registers the result.
`timescale 1ns/1ps
`include "eag_defs.svh"
module offset_adder
    import eag_pkg::*;
(
    eag_sum_if.adder sum_if
);
    logic [31:0] raw;

    always_comb begin
        raw = sum_if.term_a + sum_if.term_b + sum_if.term_c;
        // Carries out of bit 15 are lost in 16-bit addressing, as offsets wrap
        sum_if.sum = sum_if.addr32 ? raw : {16'h0000, raw[15:0]};
        sum_if.above_16 = (sum_if.sum > `EAG_LIMIT_16);
    end
endmodule : offset_adder

// >>> rtl/effective_address_generator.sv
// Purpose: Forms effective offset and linear address for one operand request.
// Assumes: Decoder holds request fields while req_valid_i is high and
//          req_ready_o is low; register file values are stable with them.
// Notes:   Avalon-MM slave gives control, sticky status, mask and last results.
`timescale 1ns/1ps
`include "eag_defs.svh"
module effective_address_generator
    import eag_pkg::*;
#(
    parameter int ADDR_W = 32,
    parameter int GPR_COUNT = 8
) (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic req_valid_i,
    output logic req_ready_o,
    input wire logic [3:0] mode_i,
    input wire logic [2:0] base_sel_i,
    input wire logic [2:0] index_sel_i,
    input wire logic [1:0] scale_i,
    input wire logic [1:0] disp_size_i,
    input wire logic [31:0] disp_i,
    input wire logic operand_width_override_i,
    input wire logic address_width_override_i,
    input wire logic default_size_flag_i,
    input wire logic legacy_mode_i,
    input wire logic [31:0] seg_base_i,
    input wire logic [GPR_COUNT*ADDR_W-1:0] gpr_i,
    output logic res_valid_o,
    output logic [31:0] effective_offset_o,
    output logic [31:0] linear_addr_o,
    output logic mem_operand_o,
    output logic addr32_o,
    output logic op32_o,
    output logic protection_fault_o,
    output logic illegal_o,
    input wire logic [2:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic irq_o
);
    // Datapath is written for a 32-bit core with eight registers
    if (ADDR_W != 32 || GPR_COUNT != 8) begin : g_check
        $error("effective_address_generator: needs ADDR_W 32 and GPR_COUNT 8");
    end

    eag_sum_if sum_if ();
    offset_adder u_adder (.sum_if(sum_if));

    // Register values seen at the current address width
    logic [31:0] gpr_w [GPR_COUNT];
    logic addr32;
    logic op32;
    logic default32;

    for (genvar k = 0; k < GPR_COUNT; k++) begin : g_gpr
        assign gpr_w[k] = addr32 ? gpr_i[k*ADDR_W +: 32] :
                          {16'h0000, gpr_i[k*ADDR_W +: 16]};
    end

    // Width selection
    always_comb begin
        default32 = default_size_flag_i && !legacy_mode_i;
        addr32 = default32 ^ address_width_override_i;
        op32 = default32 ^ operand_width_override_i;
    end

    // Decode of which components the mode uses
    logic use_base;
    logic use_index;
    logic use_scale;
    logic use_disp;
    logic is_mem;
    logic mode_bad;

    always_comb begin
        use_base = 1'b0;
        use_index = 1'b0;
        use_scale = 1'b0;
        use_disp = 1'b0;
        is_mem = 1'b1;
        mode_bad = 1'b0;
        case (mode_i)
            MODE_REGISTER, MODE_IMMEDIATE: is_mem = 1'b0;
            MODE_DIRECT: use_disp = 1'b1;
            MODE_REG_INDIRECT: use_base = 1'b1;
            MODE_BASED: begin
                use_base = 1'b1;
                use_disp = 1'b1;
            end
            MODE_INDEX: begin
                use_index = 1'b1;
                use_disp = 1'b1;
            end
            MODE_SCALED_INDEX: begin
                use_index = 1'b1;
                use_scale = 1'b1;
                use_disp = 1'b1;
            end
            MODE_BASED_INDEX: begin
                use_base = 1'b1;
                use_index = 1'b1;
            end
            MODE_BASED_SCALED: begin
                use_base = 1'b1;
                use_index = 1'b1;
                use_scale = 1'b1;
            end
            MODE_BASED_INDEX_D: begin
                use_base = 1'b1;
                use_index = 1'b1;
                use_disp = 1'b1;
            end
            MODE_BASED_SCALED_D: begin
                use_base = 1'b1;
                use_index = 1'b1;
                use_scale = 1'b1;
                use_disp = 1'b1;
            end
            default: begin
                is_mem = 1'b0;
                mode_bad = 1'b1;
            end
        endcase
    end

    // Operand terms and legality
    logic [31:0] base_term;
    logic [31:0] index_term;
    logic [31:0] disp_term;
    logic illegal;

    always_comb begin
        base_term = use_base ? gpr_w[base_sel_i] : 32'h0;
        index_term = 32'h0;
        if (use_index) begin
            // Unscaled modes multiply by one; 16-bit addressing never scales
            if (use_scale && addr32) begin
                index_term = gpr_w[index_sel_i] << scale_i;
            end else begin
                index_term = gpr_w[index_sel_i];
            end
        end
        case (disp_size_i)
            DISP_8: disp_term = {{24{disp_i[7]}}, disp_i[7:0]};
            DISP_16: disp_term = {16'h0000, disp_i[15:0]};
            DISP_32: disp_term = disp_i;
            default: disp_term = 32'h0;
        endcase
        if (!use_disp) begin
            disp_term = 32'h0;
        end
        illegal = mode_bad;
        if (is_mem && addr32) begin
            if (use_index && index_sel_i == `EAG_REG_STACK_PTR) begin
                illegal = 1'b1;
            end
            if (disp_size_i == DISP_16 && mode_i != MODE_DIRECT) begin
                illegal = 1'b1;
            end
        end
        if (is_mem && !addr32) begin
            if (use_base && base_sel_i != `EAG_REG_BASE_B &&
                base_sel_i != `EAG_REG_FRAME_PTR) begin
                illegal = 1'b1;
            end
            if (use_index && index_sel_i != `EAG_REG_SRC_INDEX &&
                index_sel_i != `EAG_REG_DEST_INDEX) begin
                illegal = 1'b1;
            end
            if ((use_scale && scale_i != 2'h0) || disp_size_i == DISP_32) begin
                illegal = 1'b1;
            end
        end
    end

    // Request sequencing and result registers
    eag_state_t state_r, state_nxt;
    logic [31:0] partial_r, partial_nxt;
    logic [31:0] disp_r, disp_nxt;
    logic [31:0] seg_r, seg_nxt;
    logic addr32_r, addr32_nxt;
    logic op32_r, op32_nxt;
    logic legacy_r, legacy_nxt;
    logic res_valid_r, res_valid_nxt;
    logic [31:0] offset_r, offset_nxt;
    logic [31:0] linear_r, linear_nxt;
    logic mem_r, mem_nxt;
    logic fault_r, fault_nxt;
    logic illegal_r, illegal_nxt;
    logic enable_r;
    logic accept;

    assign req_ready_o = (state_r == ST_IDLE) && enable_r;
    assign accept = req_valid_i && req_ready_o;

    always_comb begin
        state_nxt = state_r;
        partial_nxt = partial_r;
        disp_nxt = disp_r;
        seg_nxt = seg_r;
        addr32_nxt = addr32_r;
        op32_nxt = op32_r;
        legacy_nxt = legacy_r;
        res_valid_nxt = 1'b0;
        offset_nxt = offset_r;
        linear_nxt = linear_r;
        mem_nxt = mem_r;
        fault_nxt = fault_r;
        illegal_nxt = illegal_r;
        sum_if.term_a = base_term;
        sum_if.term_b = index_term;
        sum_if.term_c = disp_term;
        sum_if.addr32 = addr32;
        case (state_r)
            ST_IDLE: begin
                if (accept) begin
                    addr32_nxt = addr32;
                    op32_nxt = op32;
                    legacy_nxt = legacy_mode_i;
                    if (use_base && use_index && !illegal) begin
                        // Base plus index costs one more clock
                        sum_if.term_c = 32'h0;
                        partial_nxt = sum_if.sum;
                        disp_nxt = disp_term;
                        seg_nxt = seg_base_i;
                        state_nxt = ST_EXTRA;
                    end else begin
                        res_valid_nxt = 1'b1;
                        mem_nxt = is_mem;
                        illegal_nxt = illegal;
                        offset_nxt = is_mem ? sum_if.sum : 32'h0;
                        linear_nxt = is_mem ? seg_base_i + sum_if.sum : 32'h0;
                        fault_nxt = is_mem && !illegal && legacy_mode_i &&
                                    sum_if.above_16;
                    end
                end
            end
            ST_EXTRA: begin
                sum_if.term_a = partial_r;
                sum_if.term_b = 32'h0;
                sum_if.term_c = disp_r;
                sum_if.addr32 = addr32_r;
                res_valid_nxt = 1'b1;
                mem_nxt = 1'b1;
                illegal_nxt = 1'b0;
                offset_nxt = sum_if.sum;
                linear_nxt = seg_r + sum_if.sum;
                fault_nxt = legacy_r && sum_if.above_16;
                state_nxt = ST_IDLE;
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            state_r <= ST_IDLE;
            partial_r <= 32'h0;
            disp_r <= 32'h0;
            seg_r <= 32'h0;
            addr32_r <= 1'b0;
            op32_r <= 1'b0;
            legacy_r <= 1'b0;
            res_valid_r <= 1'b0;
            offset_r <= 32'h0;
            linear_r <= 32'h0;
            mem_r <= 1'b0;
            fault_r <= 1'b0;
            illegal_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            partial_r <= partial_nxt;
            disp_r <= disp_nxt;
            seg_r <= seg_nxt;
            addr32_r <= addr32_nxt;
            op32_r <= op32_nxt;
            legacy_r <= legacy_nxt;
            res_valid_r <= res_valid_nxt;
            offset_r <= offset_nxt;
            linear_r <= linear_nxt;
            mem_r <= mem_nxt;
            fault_r <= fault_nxt;
            illegal_r <= illegal_nxt;
        end
    end

    assign res_valid_o = res_valid_r;
    assign effective_offset_o = offset_r;
    assign linear_addr_o = linear_r;
    assign mem_operand_o = mem_r;
    assign addr32_o = addr32_r;
    assign op32_o = op32_r;
    assign protection_fault_o = res_valid_r && fault_r;
    assign illegal_o = res_valid_r && illegal_r;

    // Register slave: every access waits exactly one cycle
    logic ack_r, ack_nxt;
    logic enable_nxt;
    logic [`EAG_ST_W-1:0] status_r, status_nxt;
    logic [`EAG_ST_W-1:0] mask_r, mask_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [`EAG_ST_W-1:0] events;
    logic [4:0] byte_addr;
    logic wr_take;

    assign byte_addr = {avs_address, 2'b00};
    assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
    // A write lands only at the edge that completes the transfer
    assign wr_take = avs_write && ack_r && avs_byteenable[0];

    always_comb begin
        events = '0;
        events[`EAG_ST_DONE_BIT] = res_valid_r;
        events[`EAG_ST_FAULT_BIT] = res_valid_r && fault_r;
        events[`EAG_ST_ILLEGAL_BIT] = res_valid_r && illegal_r;
        ack_nxt = (avs_read || avs_write) && !ack_r;
        enable_nxt = enable_r;
        mask_nxt = mask_r;
        rdata_nxt = rdata_r;
        status_nxt = status_r;
        if (wr_take && byte_addr == `EAG_OFF_CTRL) begin
            enable_nxt = avs_writedata[`EAG_CTRL_ENABLE_BIT];
        end
        if (wr_take && byte_addr == `EAG_OFF_MASK) begin
            mask_nxt = avs_writedata[`EAG_ST_W-1:0];
        end
        if (wr_take && byte_addr == `EAG_OFF_STATUS) begin
            status_nxt = status_nxt & ~avs_writedata[`EAG_ST_W-1:0];
        end
        // A new event outranks a clear in the same cycle
        status_nxt = status_nxt | events;
        if (avs_read && !ack_r) begin
            case (byte_addr)
                `EAG_OFF_CTRL: rdata_nxt = {31'h0, enable_r};
                `EAG_OFF_STATUS: rdata_nxt = {29'h0, status_r};
                `EAG_OFF_MASK: rdata_nxt = {29'h0, mask_r};
                `EAG_OFF_LAST_OFFSET: rdata_nxt = offset_r;
                `EAG_OFF_LAST_LINEAR: rdata_nxt = linear_r;
                default: rdata_nxt = 32'h0;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            ack_r <= 1'b0;
            enable_r <= `EAG_CTRL_RESET;
            status_r <= '0;
            mask_r <= `EAG_MASK_RESET;
            rdata_r <= 32'h0;
        end else begin
            ack_r <= ack_nxt;
            enable_r <= enable_nxt;
            status_r <= status_nxt;
            mask_r <= mask_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign avs_readdata = rdata_r;
    assign irq_o = |(status_r & mask_r);

endmodule : effective_address_generator

// >>> tb/eag_properties.sv
// Purpose: Port-level checker for the effective address generator.
// Assumes: One clock domain, synchronous active-low reset.
// Notes:   Bound to the generator design module; watches request inputs and design-driven outputs.
`timescale 1ns/1ps
module eag_properties
    import eag_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic req_valid_i,
    input wire logic req_ready_o,
    input wire logic [3:0] mode_i,
    input wire logic [1:0] disp_size_i,
    input wire logic [31:0] disp_i,
    input wire logic operand_width_override_i,
    input wire logic address_width_override_i,
    input wire logic default_size_flag_i,
    input wire logic legacy_mode_i,
    input wire logic [31:0] seg_base_i,
    input wire logic res_valid_o,
    input wire logic [31:0] effective_offset_o,
    input wire logic [31:0] linear_addr_o,
    input wire logic mem_operand_o,
    input wire logic addr32_o,
    input wire logic op32_o,
    input wire logic protection_fault_o,
    input wire logic illegal_o
);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!nrst_i);

    logic take;
    assign take = req_valid_i && req_ready_o;

    sequence s_take_short;
        take && mode_i < 4'h7;
    endsequence
    sequence s_take_long;
        take && mode_i >= 4'h7 && mode_i <= 4'ha;
    endsequence
    sequence s_take_mem;
        s_take_short ##0 mode_i >= 4'h2;
    endsequence

    a_short_latency: assert property (s_take_short |=> res_valid_o)
        else $error("single cycle mode result missing");
    a_long_latency: assert property (s_take_long |-> ##[1:2] res_valid_o)
        else $error("base plus index result missing");
    a_long_busy: assert property (s_take_long |=> res_valid_o || !req_ready_o)
        else $error("no extra cycle after base plus index");
    a_fault_range: assert property (protection_fault_o |-> res_valid_o && addr32_o
        && effective_offset_o > 32'h0000ffff)
        else $error("protection fault without large offset");
    a_width_default: assert property (s_take_mem ##0 !legacy_mode_i |=> illegal_o
        || (addr32_o == ($past(default_size_flag_i) ^ $past(address_width_override_i))
        && op32_o == ($past(default_size_flag_i) ^ $past(operand_width_override_i))))
        else $error("widths do not follow default flag and prefixes");
    a_legacy_width: assert property (s_take_mem ##0 legacy_mode_i |=> illegal_o
        || (addr32_o == $past(address_width_override_i)
        && op32_o == $past(operand_width_override_i)))
        else $error("legacy widths wrong");
    a_offset_16: assert property (res_valid_o && !addr32_o |->
        effective_offset_o[31:16] == 16'h0000)
        else $error("16-bit offset not truncated");
    a_linear_sum: assert property (s_take_mem |=> illegal_o
        || linear_addr_o == $past(seg_base_i) + effective_offset_o)
        else $error("linear address is not base plus offset");
    a_direct_disp: assert property (take && mode_i == 4'h2 && disp_size_i == 2'h3 |=>
        illegal_o || effective_offset_o == $past(disp_i))
        else $error("direct offset differs from displacement");
    a_no_memory: assert property (take && mode_i < 4'h2 |=> !mem_operand_o)
        else $error("register or immediate flagged as memory");
endmodule : eag_properties

bind effective_address_generator eag_properties eag_properties_inst (.*);

// >>> tb/eag_reg_model.sv
// Purpose: General register file seen by the address generator.
// Assumes: Register values are static for the whole run.
// Notes:   Register k holds k times STEP.
`timescale 1ns/1ps
module eag_reg_model
    import eag_pkg::*;
#(
    parameter int ADDR_W = 32,
    parameter int GPR_COUNT = 8,
    parameter logic [31:0] STEP = 32'h0010_8000
) (
    output logic [GPR_COUNT*ADDR_W-1:0] gpr_o
);
    // Low halves alternate 0000 and 8000 so 16-bit sums wrap, high halves make big 32-bit offsets
    always_comb begin
        for (int k = 0; k < GPR_COUNT; k++) begin
            gpr_o[k*ADDR_W +: ADDR_W] = ADDR_W'(32'(k) * STEP);
        end
    end
endmodule : eag_reg_model

// >>> tb/effective_address_generator_tb_top.sv
// Purpose: Self-checking bench for the effective address generator.
// Assumes: Register file model supplies k*00108000 in register k.
// Notes:   Segment base and byte enables are held constant.
`timescale 1ns/1ps
module effective_address_generator_tb_top
    import eag_pkg::*;
;
    localparam logic [31:0] SEG = 32'h0004_2000;
    logic sys_clk_i = 1'b0, nrst_i = 1'b0, req_valid_i = 1'b0;
    logic operand_width_override_i = 1'b0, address_width_override_i = 1'b0;
    logic default_size_flag_i = 1'b0, legacy_mode_i = 1'b0;
    logic [3:0] mode_i = 4'h0;
    logic [2:0] base_sel_i = 3'h0, index_sel_i = 3'h0, avs_address = 3'h0;
    logic [1:0] scale_i = 2'h0, disp_size_i = 2'h0;
    logic [31:0] disp_i = 32'h0, seg_base_i = SEG, avs_writedata = 32'h0;
    logic avs_read = 1'b0, avs_write = 1'b0;
    logic [3:0] avs_byteenable = 4'hf;
    logic [255:0] gpr_i;
    logic req_ready_o, res_valid_o, mem_operand_o, addr32_o, op32_o;
    logic protection_fault_o, illegal_o, avs_waitrequest, irq_o;
    logic [31:0] effective_offset_o, linear_addr_o, avs_readdata;
    int fail_count = 0, checks = 0;

    always #5 sys_clk_i = ~sys_clk_i;

    effective_address_generator effective_address_generator_inst (.*);
    eag_reg_model eag_reg_model_inst (.gpr_o(gpr_i));

    task automatic stop_test();
        if (fail_count == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : stop_test

    task automatic chk_val(input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: expected %h got %h", $time, exp, got);
        end
    endtask : chk_val

    task automatic chk_bit(input logic exp, input logic got);
        chk_val({31'h0, exp}, {31'h0, got});
    endtask : chk_bit

    // Entered just after a rising edge; returns one edge after release
    task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge sys_clk_i iff avs_waitrequest === 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge sys_clk_i);
    endtask : bus

    // Returns at the edge that samples res_valid_o high, outputs still settled
    task automatic req(input logic [3:0] m, input logic [2:0] b, input logic [2:0] i,
                       input logic [1:0] s, input logic [1:0] ds, output int lat);
        mode_i <= m;
        base_sel_i <= b;
        index_sel_i <= i;
        scale_i <= s;
        disp_size_i <= ds;
        disp_i <= 32'h8765_1280;
        req_valid_i <= 1'b1;
        @(posedge sys_clk_i iff req_ready_o === 1'b1);
        req_valid_i <= 1'b0;
        lat = 0;
        do begin
            @(posedge sys_clk_i);
            lat++;
        end while (res_valid_o !== 1'b1 && lat < 8);
    endtask : req

    function automatic logic [31:0] eo(input logic [3:0] m, input logic [2:0] b,
        input logic [2:0] i, input logic [1:0] s, input logic [1:0] ds, input logic a32);
        logic [31:0] bv, iv, d;
        bv = 32'(b) * 32'h0010_8000;
        iv = 32'(i) * 32'h0010_8000;
        d = ds == 2'h1 ? 32'hffff_ff80 : ds == 2'h2 ? 32'h0000_1280 : ds == 2'h3 ? 32'h8765_1280 : 32'h0;
        if (!(m inside {4'h3, 4'h4, 4'h7, 4'h8, 4'h9, 4'ha})) bv = 32'h0;
        if (!(m inside {4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha})) iv = 32'h0;
        eo = bv + (iv << s) + d;
        if (!a32) eo[31:16] = 16'h0;
    endfunction : eo

    task automatic t_modes32();
        logic [3:0] m;
        logic [1:0] ds, s;
        int lat;
        default_size_flag_i <= 1'b1;
        for (int k = 2; k <= 13; k++) begin
            m = k > 10 ? 4'h6 : 4'(k);
            s = m inside {4'h6, 4'h8, 4'ha} ? 2'(k) : 2'h0;
            ds = m == 4'h2 ? 2'h3 : m inside {4'h4, 4'h5, 4'h6, 4'h9, 4'ha} ? 2'h1 : 2'h0;
            req(m, 3'h4, 3'h6, s, ds, lat);
            chk_val(eo(m, 3'h4, 3'h6, s, ds, 1'b1), effective_offset_o);
            chk_val(SEG + eo(m, 3'h4, 3'h6, s, ds, 1'b1), linear_addr_o);
            chk_val(m >= 4'h7 ? 32'h2 : 32'h1, 32'(lat));
        end
    endtask : t_modes32

    task automatic t_width();
        logic a32, o32;
        int lat;
        for (int c = 0; c < 16; c++) begin
            {legacy_mode_i, default_size_flag_i} <= 2'(c >> 2);
            {operand_width_override_i, address_width_override_i} <= 2'(c);
            a32 = c[3] ? c[0] : c[2] ^ c[0];
            o32 = c[3] ? c[1] : c[2] ^ c[1];
            req(4'h3, 3'h3, 3'h0, 2'h0, 2'h0, lat);
            chk_bit(a32, addr32_o);
            chk_bit(o32, op32_o);
            chk_val(eo(4'h3, 3'h3, 3'h0, 2'h0, 2'h0, a32), effective_offset_o);
            chk_bit(c[3] && c[0], protection_fault_o);
            chk_val(32'h1, 32'(lat));
        end
        {legacy_mode_i, default_size_flag_i, operand_width_override_i} <= 3'h0;
        address_width_override_i <= 1'b0;
    endtask : t_width

    task automatic t_sel(input logic aw, input logic [3:0] m, input logic [2:0] b,
                         input logic [2:0] i, input logic [1:0] ds, input logic ill);
        int lat;
        address_width_override_i <= aw;
        req(m, b, i, 2'h0, ds, lat);
        chk_bit(ill, illegal_o);
        if (!ill) chk_val(eo(m, b, i, 2'h0, ds, aw), effective_offset_o);
        chk_bit(m > 4'h1 && m < 4'hb, mem_operand_o);
        chk_val(m > 4'h6 && m < 4'hb && !ill ? 32'h2 : 32'h1, 32'(lat));
    endtask : t_sel

    task automatic t_16bit();
        t_sel(1'b0, 4'h7, 3'h3, 3'h7, 2'h0, 1'b0);
        t_sel(1'b0, 4'h9, 3'h5, 3'h6, 2'h2, 1'b0);
        t_sel(1'b0, 4'h4, 3'h4, 3'h0, 2'h0, 1'b1);
        t_sel(1'b0, 4'h5, 3'h0, 3'h3, 2'h1, 1'b1);
        t_sel(1'b0, 4'h4, 3'h3, 3'h0, 2'h3, 1'b1);
        t_sel(1'b1, 4'h5, 3'h0, 3'h4, 2'h1, 1'b1);
        t_sel(1'b0, 4'h0, 3'h0, 3'h0, 2'h0, 1'b0);
        t_sel(1'b0, 4'h1, 3'h0, 3'h0, 2'h0, 1'b0);
        t_sel(1'b0, 4'hb, 3'h0, 3'h0, 2'h0, 1'b1);
        address_width_override_i <= 1'b0;
    endtask : t_16bit

    task automatic t_irq();
        logic [31:0] q;
        int lat;
        bus(1'b0, 3'h0, 32'h0, q);
        chk_val(32'h1, q);
        bus(1'b0, 3'h2, 32'h0, q);
        chk_val(32'h0, q);
        bus(1'b1, 3'h7, 32'h5, q);
        bus(1'b0, 3'h7, 32'h0, q);
        chk_val(32'h0, q);
        bus(1'b1, 3'h1, 32'h7, q);
        bus(1'b1, 3'h2, 32'h2, q);
        chk_bit(1'b0, irq_o);
        legacy_mode_i <= 1'b1;
        address_width_override_i <= 1'b1;
        req(4'h3, 3'h3, 3'h0, 2'h0, 2'h0, lat);
        legacy_mode_i <= 1'b0;
        address_width_override_i <= 1'b0;
        @(posedge sys_clk_i);
        chk_bit(1'b1, irq_o);
        bus(1'b0, 3'h1, 32'h0, q);
        chk_val(32'h3, q);
        bus(1'b0, 3'h3, 32'h0, q);
        chk_val(32'h0031_8000, q);
        bus(1'b1, 3'h1, 32'h2, q);
        chk_bit(1'b0, irq_o);
        bus(1'b1, 3'h0, 32'h0, q);
        chk_bit(1'b0, req_ready_o);
        bus(1'b1, 3'h0, 32'h1, q);
        chk_bit(1'b1, req_ready_o);
    endtask : t_irq

    initial begin
        repeat (5) @(posedge sys_clk_i);
        nrst_i <= 1'b1;
        @(posedge sys_clk_i);
        t_irq();
        t_modes32();
        t_width();
        t_16bit();
        stop_test();
    end

    // Whole sequence needs well under 1000 cycles
    initial begin
        #100000;
        fail_count++;
        stop_test();
    end
endmodule : effective_address_generator_tb_top
